// ---- logic/rx_config_pkg.sv ----
// package: register map, reset values, timing counts and mask state, control and status types
package rx_config_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] RECEIVER_OPTIONS_INDEX = 8'h0B;
  localparam logic [7:0] FIRST_STAGE_GAIN_INDEX = 8'h0C;
  localparam logic [7:0] LATER_STAGE_GAIN_INDEX = 8'h0D;
  localparam logic [7:0] RECEIVE_MASK_TIME_INDEX = 8'h0E;

  localparam logic [7:0] RECEIVER_OPTIONS_RESET = 8'h1A;
  localparam logic [7:0] FIRST_STAGE_GAIN_RESET = 8'hD8;
  localparam logic [7:0] LATER_STAGE_GAIN_RESET = 8'h00;
  localparam logic [7:0] RECEIVE_MASK_TIME_RESET = 8'h08;

  // receiver_options fields
  localparam int LOW_POWER_RECEIVE_BIT = 7;
  localparam int LOW_FREQ_INPUT_SPLIT_BIT = 6;
  localparam int LF_SIGNAL_BIT = 5;
  localparam int GAIN_LOOP_ENABLE_BIT = 4;
  localparam int GAIN_LOOP_WHOLE_BIT = 3;
  localparam int GAIN_LOOP_RESET_ALG_BIT = 2;
  localparam int AUTO_SQUELCH_BIT = 1;
  localparam int PHASE_MIXER_CLOCK_BIT = 0;
  // first_stage_gain fields
  localparam int AM_FIRST_MSB = 7;
  localparam int AM_FIRST_LSB = 5;
  localparam int PM_FIRST_MSB = 4;
  localparam int PM_FIRST_LSB = 2;
  localparam int CLIP_BIT = 1;
  localparam int PEER_FORCE_BIT = 0;
  // later_stage_gain fields
  localparam int AM_LATER_MSB = 7;
  localparam int AM_LATER_LSB = 4;
  localparam int PM_LATER_MSB = 3;
  localparam int PM_LATER_LSB = 0;

  localparam logic [3:0] LATER_GAIN_MAX_CODE = 4'hA;
  localparam logic [3:0] WINDOW_MAX_STEPS = 4'h4;
  // forced -6 dB is two 3 dB stage steps
  localparam logic [2:0] FORCED_STAGE_STEPS = 3'h2;

  // mask timer, in carrier periods except MASK_MIN_COUNT, which counts steps
  localparam int MASK_STEP_FC = 64;
  localparam int DETECT_STEP_FC = 512;
  localparam logic [7:0] MASK_MIN_COUNT = 8'h04;
  localparam int SQUELCH_DELAY_FC = 256;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {MASK_IDLE = 2'b00, MASK_RUN = 2'b01}
    mask_state_type;

  typedef struct packed {
    logic lowPowerReceive;
    logic lowFreqInputSplit;
    logic lfSignalEnable;
    logic gainLoopEnable;
    logic gainLoopWholePeriod;
    logic gainLoopResetAlg;
    logic phaseMixerInternal;
    logic [2:0] amFirstStageGain;
    logic [2:0] pmFirstStageGain;
    logic clipEnable;
    logic peerModeGainForce;
    logic [2:0] amWindowSteps;
    logic [2:0] amStageSteps;
    logic [2:0] pmWindowSteps;
    logic [2:0] pmStageSteps;
  } rx_control_type;

  typedef struct packed {
    logic maskActive;
    logic squelchActive;
    logic restartNeeded;
  } rx_status_type;

endpackage

// ---- logic/rx_config_and_mask_timer.sv ----
// receiver configuration registers and mask receive timer
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/100ps
module rx_config_and_mask_timer
  import rx_config_pkg::*;
#(
  parameter int ADDR_WIDTH = 6,
  parameter int HALF_STEP_FC = 64
)(
  input wire logic clock,
  input wire logic rst,
  input wire logic [ADDR_WIDTH-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_WIDTH-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic carrierTick,
  input wire logic txEnd,
  input wire logic bitRateDetectMode,
  input wire logic typeA106Mode,
  input wire logic singleEndedMode,
  input wire logic resetRxGain,
  input wire logic setDefault,
  input wire logic receiverRestart,
  input wire logic receiverDataValid,
  output logic receiverDataPass,
  output rx_control_type control,
  output rx_status_type status
);

  // ==========================================================
  // register bus write side
  logic [7:0] receiverOptions;
  logic [7:0] firstStageGain;
  logic [7:0] laterStageGain;
  logic [7:0] receiveMaskTime;
  logic [ADDR_WIDTH-1:0] writeAddr;
  logic [7:0] writeByte;
  logic writeLane;
  logic haveAddr;
  logic haveData;

  wire takeAddr = awvalid && awready;
  wire takeData = wvalid && wready;
  wire addrReady = haveAddr || takeAddr;
  wire dataReady = haveData || takeData;
  wire doWrite = addrReady && dataReady && !bvalid;
  wire [ADDR_WIDTH-1:0] curWriteAddr = haveAddr ? writeAddr : awaddr;
  wire [7:0] curWriteByte = haveData ? writeByte : wdata[7:0];
  wire curWriteLane = haveData ? writeLane : wstrb[0];
  wire [ADDR_WIDTH-3:0] writeIndex = curWriteAddr[ADDR_WIDTH-1:2];
  wire writeHitOptions = writeIndex == RECEIVER_OPTIONS_INDEX[ADDR_WIDTH-3:0];
  wire writeHitFirst = writeIndex == FIRST_STAGE_GAIN_INDEX[ADDR_WIDTH-3:0];
  wire writeHitLater = writeIndex == LATER_STAGE_GAIN_INDEX[ADDR_WIDTH-3:0];
  wire writeHitMask = writeIndex == RECEIVE_MASK_TIME_INDEX[ADDR_WIDTH-3:0];
  wire writeHit = writeHitOptions || writeHitFirst || writeHitLater ||
    writeHitMask;
  wire writeStore = doWrite && curWriteLane;
  wire peerForceClear = writeStore && writeHitFirst &&
    firstStageGain[PEER_FORCE_BIT] && !curWriteByte[PEER_FORCE_BIT];

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      haveAddr <= 1'b0;
      haveData <= 1'b0;
      writeAddr <= '0;
      writeByte <= 8'h00;
      writeLane <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end
    else
    begin
      haveAddr <= addrReady && !doWrite;
      haveData <= dataReady && !doWrite;
      if (takeAddr)
        writeAddr <= awaddr;
      if (takeData)
      begin
        writeByte <= wdata[7:0];
        writeLane <= wstrb[0];
      end
      awready <= !addrReady && !bvalid && !awready;
      wready <= !dataReady && !bvalid && !wready;
      if (doWrite)
      begin
        bvalid <= 1'b1;
        bresp <= writeHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (bready)
        bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // register storage, defaults at reset or set-default
  always_ff @(posedge clock)
  begin
    if (rst || setDefault)
    begin
      receiverOptions <= RECEIVER_OPTIONS_RESET;
      firstStageGain <= FIRST_STAGE_GAIN_RESET;
      laterStageGain <= LATER_STAGE_GAIN_RESET;
      receiveMaskTime <= RECEIVE_MASK_TIME_RESET;
    end
    else if (writeStore)
    begin
      if (writeHitOptions)
        receiverOptions <= curWriteByte;
      if (writeHitFirst)
        firstStageGain <= curWriteByte;
      if (writeHitLater)
        laterStageGain <= curWriteByte;
      if (writeHitMask)
        receiveMaskTime <= curWriteByte;
    end
  end

  // ==========================================================
  // register bus read side
  wire [ADDR_WIDTH-3:0] readIndex = araddr[ADDR_WIDTH-1:2];
  wire readHitOptions = readIndex == RECEIVER_OPTIONS_INDEX[ADDR_WIDTH-3:0];
  wire readHitFirst = readIndex == FIRST_STAGE_GAIN_INDEX[ADDR_WIDTH-3:0];
  wire readHitLater = readIndex == LATER_STAGE_GAIN_INDEX[ADDR_WIDTH-3:0];
  wire readHitMask = readIndex == RECEIVE_MASK_TIME_INDEX[ADDR_WIDTH-3:0];
  wire readHit = readHitOptions || readHitFirst || readHitLater ||
    readHitMask;
  wire [7:0] readByte = readHitOptions ? receiverOptions :
    readHitFirst ? firstStageGain :
    readHitLater ? laterStageGain :
    readHitMask ? receiveMaskTime : 8'h00;
  wire takeRead = arvalid && arready;

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end
    else
    begin
      arready <= !rvalid && !arready && !takeRead;
      if (takeRead)
      begin
        rvalid <= 1'b1;
        rdata <= {24'h000000, readByte};
        rresp <= readHit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (rready)
        rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // later stage gain, applied only on the reset-gain command
  logic [3:0] amApplied;
  logic [3:0] pmApplied;
  wire [3:0] amLaterCode = laterStageGain[AM_LATER_MSB:AM_LATER_LSB];
  wire [3:0] pmLaterCode = laterStageGain[PM_LATER_MSB:PM_LATER_LSB];

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      amApplied <= LATER_STAGE_GAIN_RESET[AM_LATER_MSB:AM_LATER_LSB];
      pmApplied <= LATER_STAGE_GAIN_RESET[PM_LATER_MSB:PM_LATER_LSB];
    end
    else if (resetRxGain)
    begin
      amApplied <= amLaterCode > LATER_GAIN_MAX_CODE ?
        LATER_GAIN_MAX_CODE : amLaterCode;
      pmApplied <= pmLaterCode > LATER_GAIN_MAX_CODE ?
        LATER_GAIN_MAX_CODE : pmLaterCode;
    end
  end

  // window grows up to four steps, then stage gain takes the rest
  wire peerForce = firstStageGain[PEER_FORCE_BIT];
  wire amOverWindow = amApplied > WINDOW_MAX_STEPS;
  wire pmOverWindow = pmApplied > WINDOW_MAX_STEPS;
  wire [3:0] amWindow = amOverWindow ? WINDOW_MAX_STEPS : amApplied;
  wire [3:0] pmWindow = pmOverWindow ? WINDOW_MAX_STEPS : pmApplied;
  wire [3:0] amStage = amOverWindow ? amApplied - WINDOW_MAX_STEPS : 4'h0;
  wire [3:0] pmStage = pmOverWindow ? pmApplied - WINDOW_MAX_STEPS : 4'h0;

  rx_control_type next_control;
  always_comb
  begin
    next_control.lowPowerReceive =
      receiverOptions[LOW_POWER_RECEIVE_BIT];
    next_control.lowFreqInputSplit =
      receiverOptions[LOW_FREQ_INPUT_SPLIT_BIT];
    next_control.lfSignalEnable = receiverOptions[LF_SIGNAL_BIT];
    next_control.gainLoopEnable =
      receiverOptions[GAIN_LOOP_ENABLE_BIT];
    next_control.gainLoopWholePeriod =
      receiverOptions[GAIN_LOOP_WHOLE_BIT];
    next_control.gainLoopResetAlg =
      receiverOptions[GAIN_LOOP_RESET_ALG_BIT];
    next_control.phaseMixerInternal =
      receiverOptions[PHASE_MIXER_CLOCK_BIT] || singleEndedMode;
    next_control.amFirstStageGain =
      firstStageGain[AM_FIRST_MSB:AM_FIRST_LSB];
    next_control.pmFirstStageGain =
      firstStageGain[PM_FIRST_MSB:PM_FIRST_LSB];
    next_control.clipEnable = firstStageGain[CLIP_BIT];
    next_control.peerModeGainForce = peerForce;
    next_control.amWindowSteps = peerForce ? WINDOW_MAX_STEPS[2:0] :
      amWindow[2:0];
    next_control.pmWindowSteps = peerForce ? WINDOW_MAX_STEPS[2:0] :
      pmWindow[2:0];
    next_control.amStageSteps = peerForce ? FORCED_STAGE_STEPS : amStage[2:0];
    next_control.pmStageSteps = peerForce ? FORCED_STAGE_STEPS : pmStage[2:0];
  end

  // ==========================================================
  // mask receive timer and automatic squelch
  mask_state_type maskState;
  logic [16:0] elapsedFc;
  logic [16:0] maskLimit;
  logic restartNeeded;

  wire [7:0] maskCount = receiveMaskTime < MASK_MIN_COUNT ?
    MASK_MIN_COUNT : receiveMaskTime;
  wire [9:0] stepFc = bitRateDetectMode ? 10'(DETECT_STEP_FC) :
    typeA106Mode ? 10'(HALF_STEP_FC) : 10'(MASK_STEP_FC);
  wire [16:0] next_maskLimit = 17'(maskCount * stepFc);
  wire maskDone = maskState == MASK_RUN && carrierTick &&
    elapsedFc + 17'h00001 >= maskLimit;
  wire masking = maskState == MASK_RUN;
  wire next_squelch = masking && !maskDone &&
    receiverOptions[AUTO_SQUELCH_BIT] &&
    elapsedFc + 17'(carrierTick) >= 17'(SQUELCH_DELAY_FC);

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      maskState <= MASK_IDLE;
      elapsedFc <= 17'h00000;
      maskLimit <= 17'h00000;
    end
    else if (txEnd)
    begin
      maskState <= MASK_RUN;
      elapsedFc <= 17'h00000;
      maskLimit <= next_maskLimit;
    end
    else
    begin
      case (maskState)
        MASK_RUN:
        begin
          if (maskDone)
            maskState <= MASK_IDLE;
          if (carrierTick)
            elapsedFc <= elapsedFc + 17'h00001;
        end
        default:
          maskState <= MASK_IDLE;
      endcase
    end
  end

  // restart flag: clearing the force bit wins over a restart pulse
  always_ff @(posedge clock)
  begin
    if (rst)
      restartNeeded <= 1'b0;
    else if (peerForceClear)
      restartNeeded <= 1'b1;
    else if (receiverRestart)
      restartNeeded <= 1'b0;
  end

  // ==========================================================
  // registered outputs
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      control <= '0;
      status <= '0;
      receiverDataPass <= 1'b0;
    end
    else
    begin
      control <= next_control;
      status.maskActive <= masking && !maskDone;
      status.squelchActive <= next_squelch;
      status.restartNeeded <= restartNeeded;
      receiverDataPass <= receiverDataValid && !masking;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  property p_low_power;
    ##1 control.lowPowerReceive == $past(receiverOptions[7]);
  endproperty
  a_low_power: assert property (p_low_power)
    else $error("low power output does not follow its bit");

  property p_mixer_single;
    singleEndedMode |=> control.phaseMixerInternal;
  endproperty
  a_mixer_single: assert property (p_mixer_single)
    else $error("single-ended mode did not force internal mixer clock");

  property p_gain_hold;
    !resetRxGain && !rst |=> $stable(amApplied) && $stable(pmApplied);
  endproperty
  a_gain_hold: assert property (p_gain_hold)
    else $error("applied gain changed without reset-gain command");

  property p_force_window;
    peerForce |=> control.amStageSteps == 3'h2 &&
      control.pmWindowSteps == 3'h4;
  endproperty
  a_force_window: assert property (p_force_window)
    else $error("forced gain not applied");

  property p_mask_min;
    txEnd |=> maskLimit >= 17'(MASK_MIN_COUNT) * 17'(MASK_STEP_FC);
  endproperty
  a_mask_min: assert property (p_mask_min)
    else $error("mask interval below minimum");

  property p_mask_detect;
    txEnd && bitRateDetectMode |=> maskLimit == {$past(maskCount), 9'h000};
  endproperty
  a_mask_detect: assert property (p_mask_detect)
    else $error("detect mode step is not 512 carrier periods");

  sequence s_masking;
    masking && receiverDataValid;
  endsequence
  property p_data_blocked;
    s_masking |=> !receiverDataPass;
  endproperty
  a_data_blocked: assert property (p_data_blocked)
    else $error("receiver output passed during mask");

  property p_squelch_off;
    !receiverOptions[AUTO_SQUELCH_BIT] |=> !status.squelchActive;
  endproperty
  a_squelch_off: assert property (p_squelch_off)
    else $error("squelch active while automatic squelch disabled");

  property p_defaults;
    setDefault |=> receiveMaskTime == 8'h08 && receiverOptions == 8'h1A &&
      firstStageGain == 8'hD8;
  endproperty
  a_defaults: assert property (p_defaults)
    else $error("set-default did not restore defaults");

endmodule

// ---- dv/tb_rx_config_and_mask_timer.sv ----
// testbench for the receiver configuration registers and mask timer
`timescale 1ns/100ps
module tb_rx_config_and_mask_timer
  import rx_config_pkg::*;
;
  // ==================================================
  // signals
  localparam int HALF = 96;
  logic clock, rst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, carrierTick, txEnd;
  logic bitRateDetectMode, typeA106Mode, singleEndedMode, resetRxGain;
  logic setDefault, receiverRestart, receiverDataValid, receiverDataPass;
  logic [5:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  rx_control_type control;
  rx_status_type status;
  int failures, checks;

  rx_config_and_mask_timer #(.ADDR_WIDTH(6), .HALF_STEP_FC(HALF))
    rx_config_and_mask_timer_inst (.clock(clock), .rst(rst),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .carrierTick(carrierTick), .txEnd(txEnd),
    .bitRateDetectMode(bitRateDetectMode), .typeA106Mode(typeA106Mode),
    .singleEndedMode(singleEndedMode), .resetRxGain(resetRxGain),
    .setDefault(setDefault), .receiverRestart(receiverRestart),
    .receiverDataValid(receiverDataValid),
    .receiverDataPass(receiverDataPass), .control(control),
    .status(status));

  initial
  begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // ==================================================
  // helpers
  task automatic wrap_up;
    if (failures == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[ERR] %0t got %0h exp %0h", $time, got, exp);
    end
  endtask

  task automatic guard(inout int n);
    n++;
    if (n > 3000)
    begin
      chk(32'(n), 32'h0);
      wrap_up();
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clock);
  endtask

  function automatic logic [5:0] adr(input logic [7:0] idx);
    return {idx[3:0], 2'b00};
  endfunction

  task automatic wr(input logic [7:0] idx, input logic [7:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    int n;
    logic ta;
    logic td;
    n = 0;
    ta = 1'b0;
    td = 1'b0;
    awaddr <= adr(idx);
    wdata <= {24'h000000, d};
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clock);
      guard(n);
      ta = ta | awready;
      td = td | wready;
      awvalid <= !ta;
      wvalid <= !td;
    end
    while (!bvalid);
    chk({30'h0, bresp}, {30'h0, er});
    bready <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] exp,
                    input logic [1:0] er);
    int n;
    logic ta;
    n = 0;
    ta = 1'b0;
    araddr <= adr(idx);
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clock);
      guard(n);
      ta = ta | arready;
      arvalid <= !ta;
    end
    while (!rvalid);
    chk({30'h0, rresp}, {30'h0, er});
    chk(rdata, {24'h000000, exp});
    rready <= 1'b0;
    @(posedge clock);
  endtask

  // expected control outputs from register values and applied gain
  function automatic rx_control_type ec(input logic [7:0] o,
    input logic [7:0] f, input logic [3:0] am, input logic [3:0] pm,
    input logic se);
    rx_control_type e;
    logic [3:0] a;
    logic [3:0] p;
    a = (am > 4'hA) ? 4'hA : am;
    p = (pm > 4'hA) ? 4'hA : pm;
    e.lowPowerReceive = o[7];
    e.lowFreqInputSplit = o[6];
    e.lfSignalEnable = o[5];
    e.gainLoopEnable = o[4];
    e.gainLoopWholePeriod = o[3];
    e.gainLoopResetAlg = o[2];
    e.phaseMixerInternal = o[0] | se;
    e.amFirstStageGain = f[7:5];
    e.pmFirstStageGain = f[4:2];
    e.clipEnable = f[1];
    e.peerModeGainForce = f[0];
    e.amWindowSteps = f[0] ? 3'h4 : (a > 4'h4 ? 3'h4 : a[2:0]);
    e.amStageSteps = f[0] ? 3'h2 : (a > 4'h4 ? 3'(a - 4'h4) : 3'h0);
    e.pmWindowSteps = f[0] ? 3'h4 : (p > 4'h4 ? 3'h4 : p[2:0]);
    e.pmStageSteps = f[0] ? 3'h2 : (p > 4'h4 ? 3'(p - 4'h4) : 3'h0);
    return e;
  endfunction

  task automatic cc(input rx_control_type e);
    chk(32'(control), 32'(e));
  endtask

  // one masking interval: a tick every third cycle, lim ticks expected
  task automatic mrun(input logic [7:0] v, input logic det,
                      input logic ta, input logic sq, input int lim);
    int n;
    int g;
    wr(RECEIVE_MASK_TIME_INDEX, v, 4'hF, RESP_OKAY);
    bitRateDetectMode <= det;
    typeA106Mode <= ta;
    txEnd <= 1'b1;
    @(posedge clock);
    txEnd <= 1'b0;
    @(posedge clock);
    n = 0;
    g = 0;
    forever
    begin
      @(posedge clock);
      guard(g);
      chk({30'h0, status.maskActive, status.squelchActive},
          {30'h0, n < lim, sq && n >= 256 && n < lim});
      if (n > 0 && n < lim)
        chk({31'h0, receiverDataPass}, 32'h0);
      if (n == lim)
        break;
      carrierTick <= 1'b1;
      @(posedge clock);
      carrierTick <= 1'b0;
      n++;
      @(posedge clock);
    end
    cyc(2);
    chk({31'h0, receiverDataPass}, 32'h1);
    receiverDataValid <= 1'b0;
    cyc(2);
    chk({31'h0, receiverDataPass}, 32'h0);
    receiverDataValid <= 1'b1;
    bitRateDetectMode <= 1'b0;
    typeA106Mode <= 1'b0;
  endtask

  // ==================================================
  // scenarios
  task automatic t_reset;
    rd(RECEIVER_OPTIONS_INDEX, 8'h1A, RESP_OKAY);
    rd(FIRST_STAGE_GAIN_INDEX, 8'hD8, RESP_OKAY);
    rd(LATER_STAGE_GAIN_INDEX, 8'h00, RESP_OKAY);
    rd(RECEIVE_MASK_TIME_INDEX, 8'h08, RESP_OKAY);
    rd(8'h01, 8'h00, RESP_SLVERR);
    cc(ec(8'h1A, 8'hD8, 4'h0, 4'h0, 1'b0));
  endtask

  task automatic t_mask;
    mrun(8'h00, 1'b0, 1'b0, 1'b1, 256);
    mrun(8'h05, 1'b0, 1'b0, 1'b1, 320);
    mrun(8'h02, 1'b1, 1'b0, 1'b1, 2048);
    mrun(8'h06, 1'b0, 1'b1, 1'b1, 6 * HALF);
  endtask

  task automatic t_options;
    wr(RECEIVER_OPTIONS_INDEX, 8'hE4, 4'h1, RESP_OKAY);
    cyc(2);
    cc(ec(8'hE4, 8'hD8, 4'h0, 4'h0, 1'b0));
    singleEndedMode <= 1'b1;
    cyc(3);
    cc(ec(8'hE4, 8'hD8, 4'h0, 4'h0, 1'b1));
    rd(RECEIVER_OPTIONS_INDEX, 8'hE4, RESP_OKAY);
    mrun(8'h05, 1'b0, 1'b0, 1'b0, 320);
    singleEndedMode <= 1'b0;
    wr(RECEIVER_OPTIONS_INDEX, 8'h19, 4'h1, RESP_OKAY);
    cyc(2);
    cc(ec(8'h19, 8'hD8, 4'h0, 4'h0, 1'b0));
  endtask

  task automatic t_gain;
    wr(FIRST_STAGE_GAIN_INDEX, 8'hE7, 4'h1, RESP_OKAY);
    cyc(2);
    cc(ec(8'h19, 8'hE7, 4'h0, 4'h0, 1'b0));
    wr(FIRST_STAGE_GAIN_INDEX, 8'h24, 4'h1, RESP_OKAY);
    cyc(2);
    chk(32'(status), 32'h1);
    receiverRestart <= 1'b1;
    @(posedge clock);
    receiverRestart <= 1'b0;
    cyc(2);
    chk(32'(status), 32'h0);
    wr(LATER_STAGE_GAIN_INDEX, 8'h7A, 4'h1, RESP_OKAY);
    cyc(2);
    cc(ec(8'h19, 8'h24, 4'h0, 4'h0, 1'b0));
    resetRxGain <= 1'b1;
    @(posedge clock);
    resetRxGain <= 1'b0;
    cyc(3);
    cc(ec(8'h19, 8'h24, 4'h7, 4'hA, 1'b0));
    rd(LATER_STAGE_GAIN_INDEX, 8'h7A, RESP_OKAY);
  endtask

  task automatic t_default;
    wr(RECEIVE_MASK_TIME_INDEX, 8'h55, 4'h0, RESP_OKAY);
    rd(RECEIVE_MASK_TIME_INDEX, 8'h05, RESP_OKAY);
    wr(8'h00, 8'hFF, 4'hF, RESP_SLVERR);
    setDefault <= 1'b1;
    @(posedge clock);
    setDefault <= 1'b0;
    resetRxGain <= 1'b1;
    @(posedge clock);
    resetRxGain <= 1'b0;
    cyc(3);
    rd(RECEIVER_OPTIONS_INDEX, 8'h1A, RESP_OKAY);
    rd(FIRST_STAGE_GAIN_INDEX, 8'hD8, RESP_OKAY);
    rd(LATER_STAGE_GAIN_INDEX, 8'h00, RESP_OKAY);
    rd(RECEIVE_MASK_TIME_INDEX, 8'h08, RESP_OKAY);
    cc(ec(8'h1A, 8'hD8, 4'h0, 4'h0, 1'b0));
  endtask

  // ==================================================
  // main sequence
  initial
  begin
    failures = 0;
    checks = 0;
    rst = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready, carrierTick} = 6'h00;
    {txEnd, bitRateDetectMode, typeA106Mode, singleEndedMode} = 4'h0;
    {resetRxGain, setDefault, receiverRestart} = 3'h0;
    receiverDataValid = 1'b1;
    awaddr = 6'h00;
    araddr = 6'h00;
    wdata = 32'h00000000;
    wstrb = 4'h0;
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    cyc(2);
    t_reset();
    t_mask();
    t_options();
    t_gain();
    t_default();
    wrap_up();
  end
endmodule
